/* core/bscl_latch.v */
// Boot strap configuration latch with APB access to the captured settings
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "bscl_map.vh"


module bscl_latch (
   // APB clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // Chip resets, synchronous to pclk
   input wire reset_n,
   input wire clock_generator_reset_n,
   // Address pad: level seen, board drive, core drive
   input wire [19:0] addr_pin_in,
   input wire [19:0] addr_board_drive,
   output reg [19:0] addr_out,
   output reg [19:0] addr_oe_n,
   // Data pad: level seen, board drive, core drive
   input wire [15:0] data_pin_in,
   input wire [15:0] data_board_drive,
   output reg [15:0] data_out,
   output reg [15:0] data_oe_n,
   // Normal bus traffic from the rest of the chip
   input wire [19:0] core_addr,
   input wire [19:0] core_addr_en,
   input wire [15:0] core_data,
   input wire [15:0] core_data_en,
   // Clock generator settings
   output reg clock_generator_init,
   output reg [3:0] core_clock_mult,
   output reg [3:0] pci_clock_div,
   output reg [2:0] external_system_clock_div,
   // PCI controller settings
   output reg pci_host_mode,
   output reg pci_arbiter_sel,
   // External bus controller boot settings
   output reg boot_from_pci,
   output reg boot_from_ext_mem,
   output reg [2:0] boot_clock_div,
   output reg boot_sel_reserved,
   output reg byte_write_enable_mode,
   output reg ack_external,
   output reg [1:0] boot_bus_width,
   // Miscellaneous settings
   output reg [3:0] shared_pin_sel,
   output reg big_endian,
   output reg [7:0] board_info,
   output reg core_timer_int_en
);

   // Strap registers and their reset trackers
   reg [19:0] addr_cfg;
   reg [15:0] data_cfg;
   reg gen_rst_q;
   reg cg_rst_q;
   reg gen_done;
   reg cg_done;
   reg cfg_lock;
   reg pins_released;

   // Pad level after the internal pull-up
   wire [19:0] addr_strap;
   wire [15:0] data_strap;

   // Release edges and bus qualifiers
   wire gen_release;
   wire cg_release;
   wire any_in_reset;
   wire apb_setup;
   wire apb_write;
   wire [19:0] next_addr_cfg;
   wire [15:0] next_data_cfg;
   wire [2:0] boot_field;
   wire [1:0] sys_field;
   wire [1:0] ebc_field;

   // Each pad reads its board level only when the board drives it
   // A floating pad would otherwise read unknown and spoil the capture
   genvar i;
   generate
      for (i = 0; i < 36; i = i + 1) begin : g_pull
         if (i < 20) begin : g_a
            assign addr_strap[i] = addr_board_drive[i] ? addr_pin_in[i] : 1'b1;
         end else begin : g_d
            assign data_strap[i-20] = data_board_drive[i-20] ? data_pin_in[i-20] : 1'b1;
         end
      end
   endgenerate

   // A release is the first cycle a reset is seen high after being low
   // A joint release loads both field groups in the same cycle
   assign gen_release = reset_n & ~gen_rst_q;
   assign cg_release = clock_generator_reset_n & ~cg_rst_q;
   assign any_in_reset = ~reset_n | ~clock_generator_reset_n;

   // Zero wait state slave; read data is set up during the setup cycle
   // Only the two strap words obey the lock; status and control stay writable
   assign pready = 1'b1;
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite & ~cfg_lock &
                      (paddr == `BSCL_OFF_ADDR_CFG || paddr == `BSCL_OFF_DATA_CFG);

   // Each release reloads only its own fields and keeps the rest,
   // so one reset never disturbs settings owned by the other
   assign next_addr_cfg =
      (cg_release ? (addr_strap & `BSCL_ADDR_CG_MASK) : (addr_cfg & `BSCL_ADDR_CG_MASK)) |
      (gen_release ? (addr_strap & `BSCL_ADDR_GEN_MASK) : (addr_cfg & `BSCL_ADDR_GEN_MASK));
   assign next_data_cfg = gen_release ? data_strap : data_cfg;

   // Reset trackers; presetn idles them low so power-up counts as a release
   // Hazard: hold reset_n low across presetn release unless that capture is wanted
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_rst_q <= 1'b0;
         cg_rst_q <= 1'b0;
      end else begin
         gen_rst_q <= reset_n;
         cg_rst_q <= clock_generator_reset_n;
      end
   end

   // Captured strap words; pins are ignored outside a release cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_cfg <= `BSCL_ADDR_RST;
         data_cfg <= `BSCL_DATA_RST;
      end else if (gen_release || cg_release) begin
         addr_cfg <= next_addr_cfg;
         data_cfg <= next_data_cfg;
      end else if (apb_write && paddr == `BSCL_OFF_ADDR_CFG) begin
         addr_cfg <= pwdata[19:0];
      end else if (apb_write) begin
         data_cfg <= pwdata[15:0];
      end
   end

   // Completion flags: set by release, cleared by writing one; set wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_done <= 1'b0;
         cg_done <= 1'b0;
      end else begin
         // General reset completion
         if (gen_release) begin
            gen_done <= 1'b1;
         end else if (psel && penable && pwrite && paddr == `BSCL_OFF_STATUS &&
                      pwdata[`BSCL_ST_GEN_DONE]) begin
            gen_done <= 1'b0;
         end
         // Clock-generator reset completion
         if (cg_release) begin
            cg_done <= 1'b1;
         end else if (psel && penable && pwrite && paddr == `BSCL_OFF_STATUS &&
                      pwdata[`BSCL_ST_CG_DONE]) begin
            cg_done <= 1'b0;
         end
      end
   end

   // Lock bit; once set only presetn clears it, so boot code can seal the straps
   // Limitation: once sealed, only a new strap release changes the words
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_lock <= `BSCL_CTRL_RST;
      end else if (psel && penable && pwrite && paddr == `BSCL_OFF_CTRL &&
                   pwdata[`BSCL_CT_LOCK]) begin
         cfg_lock <= 1'b1;
      end
   end

   // Pads stay released through reset and the capture cycle itself
   // The extra released cycle keeps core drive off the pads at the sample edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_released <= 1'b1;
      end else begin
         pins_released <= any_in_reset;
      end
   end

   // Normal bus drive; oe_n is low only where the core drives the pad
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_out <= 20'h00000;
         addr_oe_n <= 20'hfffff;
         data_out <= 16'h0000;
         data_oe_n <= 16'hffff;
      end else if (any_in_reset || pins_released) begin
         addr_out <= 20'h00000;
         addr_oe_n <= 20'hfffff;
         data_out <= 16'h0000;
         data_oe_n <= 16'hffff;
      end else begin
         // Core drive takes over one cycle after both resets are seen high
         addr_out <= core_addr;
         addr_oe_n <= ~core_addr_en;
         data_out <= core_data;
         data_oe_n <= ~core_data_en;
      end
   end

   // Field slices used by the decoders
   // Boot field is the memory-select bit above the two divider bits
   assign boot_field = addr_cfg[`BSCL_A_BOOT_HI:`BSCL_A_BOOT_LO];
   assign sys_field = addr_cfg[`BSCL_A_SYSDIV_HI:`BSCL_A_SYSDIV_LO];
   assign ebc_field = addr_cfg[`BSCL_A_BOOT_LO+1:`BSCL_A_BOOT_LO];

   // Clock generator outputs; init stands while its reset is low
   // Ratios track addr_cfg a cycle late, so they settle one cycle after init drops; the generator must wait for that
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_generator_init <= 1'b1;
         core_clock_mult <= 4'hf;
         pci_clock_div <= 4'hb;
         external_system_clock_div <= 3'h1;
      end else begin
         clock_generator_init <= ~clock_generator_reset_n;
         core_clock_mult <= addr_cfg[`BSCL_A_MULT_HI:`BSCL_A_MULT_LO];
         // LL..HH map to 8..11
         pci_clock_div <= `BSCL_PCIDIV_BASE |
                          {2'b00, addr_cfg[`BSCL_A_PCIDIV_HI:`BSCL_A_PCIDIV_LO]};
         // LL..HH map to 4, 3, 2, 1
         external_system_clock_div <= `BSCL_DIV4 - {1'b0, sys_field};
      end
   end

   // PCI controller outputs
   // Arbiter select is passed raw; its polarity is left to the PCI controller
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pci_host_mode <= 1'b1;
         pci_arbiter_sel <= 1'b1;
      end else begin
         pci_host_mode <= addr_cfg[`BSCL_A_PCI_HOST];
         pci_arbiter_sel <= data_cfg[`BSCL_D_ARB];
      end
   end

   // External bus controller boot outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_from_pci <= 1'b0;
         boot_from_ext_mem <= 1'b1;
         boot_clock_div <= 3'h1;
         boot_sel_reserved <= 1'b0;
         byte_write_enable_mode <= 1'b1;
         ack_external <= 1'b1;
         boot_bus_width <= 2'h3;
      end else begin
         boot_from_pci <= (boot_field == `BSCL_PCI_BOOT_CODE);
         boot_from_ext_mem <= addr_cfg[`BSCL_A_BOOT_HI];
         // HH..LL map to 1..4
         boot_clock_div <= `BSCL_DIV4 - {1'b0, ebc_field};
         // Low top bit with anything but HH below is a reserved code
         boot_sel_reserved <= ~addr_cfg[`BSCL_A_BOOT_HI] & ~(&ebc_field);
         byte_write_enable_mode <= data_cfg[`BSCL_D_BYTE_WE];
         ack_external <= data_cfg[`BSCL_D_ACK_EXT];
         boot_bus_width <= data_cfg[`BSCL_D_WIDTH_HI:`BSCL_D_WIDTH_LO];
      end
   end

   // Shared pins, endianness, board information and timer interrupt
   // Shared selects in order: address 18, address 9, data 6, data 3
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_pin_sel <= 4'hf;
         big_endian <= 1'b1;
         board_info <= 8'hff;
         core_timer_int_en <= 1'b1;
      end else begin
         shared_pin_sel <= {addr_cfg[`BSCL_A_SHARED_HI], addr_cfg[`BSCL_A_SHARED_LO],
                            data_cfg[`BSCL_D_SHARED_HI], data_cfg[`BSCL_D_SHARED_LO]};
         big_endian <= addr_cfg[`BSCL_A_ENDIAN];
         board_info <= data_cfg[`BSCL_D_BOARD_HI:`BSCL_D_BOARD_LO];
         core_timer_int_en <= data_cfg[`BSCL_D_TIMER_EN];
      end
   end

   // Read data and error are prepared in the setup cycle, held in access
   // Trade-off: a read shows state as of its setup cycle, one cycle old
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (apb_setup) begin
         pslverr <= 1'b0;
         case (paddr)
            `BSCL_OFF_ADDR_CFG: begin
               prdata <= {12'h000, addr_cfg};
            end
            `BSCL_OFF_DATA_CFG: begin
               prdata <= {16'h0000, data_cfg};
            end
            `BSCL_OFF_STATUS: begin
               prdata <= {27'h0000000, boot_sel_reserved, cg_done, gen_done,
                          ~clock_generator_reset_n, ~reset_n};
            end
            `BSCL_OFF_CTRL: begin
               prdata <= {31'h00000000, cfg_lock};
            end
            default: begin
               // Unmapped words read zero and flag an error
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end

endmodule // bscl_latch

/* common/bscl_map.vh */
// Register map, field positions and reset values of the boot strap latch
`ifndef BSCL_MAP_VH
`define BSCL_MAP_VH

// Register byte offsets
`define BSCL_OFF_ADDR_CFG 12'h000
`define BSCL_OFF_DATA_CFG 12'h004
`define BSCL_OFF_STATUS 12'h008
`define BSCL_OFF_CTRL 12'h00c

// Widths of the strapped buses
`define BSCL_ADDR_W 20
`define BSCL_DATA_W 16

// Reset values: every strap reads high through its pull-up
`define BSCL_ADDR_RST 20'hfffff
`define BSCL_DATA_RST 16'hffff

// Address straps loaded by the clock-generator reset release
`define BSCL_ADDR_CG_MASK 20'h06c0f
// Address straps loaded by the general reset release
`define BSCL_ADDR_GEN_MASK 20'hf93f0

// Address strap fields
`define BSCL_A_PCI_HOST 19
`define BSCL_A_SHARED_HI 18
`define BSCL_A_SYSDIV_HI 14
`define BSCL_A_SYSDIV_LO 13
`define BSCL_A_ENDIAN 12
`define BSCL_A_PCIDIV_HI 11
`define BSCL_A_PCIDIV_LO 10
`define BSCL_A_SHARED_LO 9
`define BSCL_A_BOOT_HI 8
`define BSCL_A_BOOT_LO 6
`define BSCL_A_MULT_HI 3
`define BSCL_A_MULT_LO 0

// Data strap fields
`define BSCL_D_BOARD_HI 15
`define BSCL_D_BOARD_LO 8
`define BSCL_D_TIMER_EN 7
`define BSCL_D_SHARED_HI 6
`define BSCL_D_BYTE_WE 5
`define BSCL_D_ACK_EXT 4
`define BSCL_D_SHARED_LO 3
`define BSCL_D_ARB 2
`define BSCL_D_WIDTH_HI 1
`define BSCL_D_WIDTH_LO 0

// Status bit positions
`define BSCL_ST_GEN_RST 0
`define BSCL_ST_CG_RST 1
`define BSCL_ST_GEN_DONE 2
`define BSCL_ST_CG_DONE 3
`define BSCL_ST_BOOT_BAD 4

// Control bit positions and reset value
`define BSCL_CT_LOCK 0
`define BSCL_CTRL_RST 1'b0

// Fixed bases of the decoded clock ratios and the PCI boot code
`define BSCL_PCIDIV_BASE 4'h8
`define BSCL_DIV4 3'h4
`define BSCL_PCI_BOOT_CODE 3'h3

`endif

/* test/bscl_latch_properties.sv */
// Port-level checks of strap capture and decode for the strap latch
`timescale 1ns/1ps
module bscl_latch_properties (
   // Clock and resets
   input wire pclk,
   input wire presetn,
   input wire reset_n,
   input wire clock_generator_reset_n,
   // Pads
   input wire [19:0] addr_pin_in,
   input wire [15:0] data_pin_in,
   input wire [19:0] addr_oe_n,
   input wire [15:0] data_oe_n,
   // Decoded settings
   input wire clock_generator_init,
   input wire [3:0] core_clock_mult,
   input wire [3:0] pci_clock_div,
   input wire [2:0] external_system_clock_div,
   input wire pci_host_mode,
   input wire pci_arbiter_sel,
   input wire boot_from_pci,
   input wire boot_from_ext_mem,
   input wire byte_write_enable_mode,
   input wire ack_external,
   input wire [1:0] boot_bus_width,
   input wire [3:0] shared_pin_sel,
   input wire big_endian,
   input wire [7:0] board_info,
   input wire core_timer_int_en
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Captures land two edges after the release edge, where pins were sampled
   chk_pads_released: assert property (!reset_n |=> &addr_oe_n && &data_oe_n)
      else $error("pads driven in reset");
   chk_cg_init: assert property (!clock_generator_reset_n |=> clock_generator_init)
      else $error("clock generator init missing");
   chk_gen_modes: assert property ($rose(reset_n) |-> ##2
      {pci_host_mode, big_endian} == {$past(addr_pin_in[19], 2), $past(addr_pin_in[12], 2)})
      else $error("host or endian wrong");
   chk_pci_div: assert property ($rose(clock_generator_reset_n) |-> ##2
      pci_clock_div == 4'h8 + {2'h0, $past(addr_pin_in[11:10], 2)}) else $error("pci div");
   chk_sys_div: assert property ($rose(clock_generator_reset_n) |-> ##2
      external_system_clock_div == 3'h4 - {1'h0, $past(addr_pin_in[14:13], 2)}) else $error("sys div");
   chk_core_mult: assert property ($rose(clock_generator_reset_n) |-> ##2
      core_clock_mult == $past(addr_pin_in[3:0], 2)) else $error("core mult");
   chk_boot_dev: assert property ($rose(reset_n) |-> ##2
      boot_from_pci == ($past(addr_pin_in[8:6], 2) == 3'h3) &&
      boot_from_ext_mem == $past(addr_pin_in[8], 2)) else $error("boot device");
   chk_board_info: assert property ($rose(reset_n) |-> ##2
      board_info == $past(data_pin_in[15:8], 2)) else $error("board info");
   chk_data_opts: assert property ($rose(reset_n) |->
      ##2 {pci_arbiter_sel, byte_write_enable_mode, ack_external, core_timer_int_en} ==
      {$past(data_pin_in[2], 2), $past(data_pin_in[5], 2), $past(data_pin_in[4], 2),
      $past(data_pin_in[7], 2)}) else $error("bus options");
   chk_bus_width: assert property ($rose(reset_n) |-> ##2
      boot_bus_width == $past(data_pin_in[1:0], 2)) else $error("bus width");
   chk_shared_sel: assert property ($rose(reset_n) |-> ##2
      shared_pin_sel == {$past(addr_pin_in[18], 2), $past(addr_pin_in[9], 2),
      $past(data_pin_in[6], 2), $past(data_pin_in[3], 2)}) else $error("shared pins");
endmodule // bscl_latch_properties

bind bscl_latch bscl_latch_properties u_bscl_latch_properties (
   .pclk(pclk), .presetn(presetn), .reset_n(reset_n),
   .clock_generator_reset_n(clock_generator_reset_n),
   .addr_pin_in(addr_pin_in), .data_pin_in(data_pin_in),
   .addr_oe_n(addr_oe_n), .data_oe_n(data_oe_n),
   .clock_generator_init(clock_generator_init), .core_clock_mult(core_clock_mult),
   .pci_clock_div(pci_clock_div), .external_system_clock_div(external_system_clock_div),
   .pci_host_mode(pci_host_mode), .pci_arbiter_sel(pci_arbiter_sel),
   .boot_from_pci(boot_from_pci), .boot_from_ext_mem(boot_from_ext_mem),
   .byte_write_enable_mode(byte_write_enable_mode), .ack_external(ack_external),
   .boot_bus_width(boot_bus_width), .shared_pin_sel(shared_pin_sel),
   .big_endian(big_endian), .board_info(board_info),
   .core_timer_int_en(core_timer_int_en));

/* test/bscl_board.sv */
// Board strap resistors and pad level resolution
`timescale 1ns/1ps
module bscl_board (
   // Strap settings from the bench
   input wire [19:0] strap_addr,
   input wire [19:0] strap_addr_drv,
   input wire [15:0] strap_data,
   input wire [15:0] strap_data_drv,
   // Device pad drive
   input wire [19:0] addr_out,
   input wire [19:0] addr_oe_n,
   input wire [15:0] data_out,
   input wire [15:0] data_oe_n,
   // Pad levels seen by the device
   output wire [19:0] addr_pin_in,
   output wire [19:0] addr_board_drive,
   output wire [15:0] data_pin_in,
   output wire [15:0] data_board_drive
);
   // Reserved straps 17:15 are never pulled low by this board
   assign addr_board_drive = strap_addr_drv & ~20'h38000;
   assign data_board_drive = strap_data_drv;
   // Board resistor wins, else device drive, else the internal pull-up
   assign addr_pin_in = (addr_board_drive & strap_addr) |
      (~addr_board_drive & (addr_oe_n | addr_out));
   assign data_pin_in = (data_board_drive & strap_data) |
      (~data_board_drive & (data_oe_n | data_out));
endmodule // bscl_board

/* test/boot_strap_config_latch_test.sv */
// Self-checking bench for the boot strap latch
`timescale 1ns/1ps
`include "bscl_map.vh"
module boot_strap_config_latch_test;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reset_n = 1'b0, cg_n = 1'b0, erv;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rdv;
   reg [19:0] s_a = 20'h0, s_ad = 20'h0, c_a = 20'habcde, c_ae = 20'hfffff, ea = 20'hfffff;
   reg [15:0] s_d = 16'h0, s_dd = 16'h0, c_d = 16'h1234, c_de = 16'hffff, ed = 16'hffff;
   wire pready, pslverr, cg_init;
   wire [31:0] prdata;
   wire [19:0] a_pin, a_bd, a_out, a_oe_n;
   wire [15:0] d_pin, d_bd, d_out, d_oe_n;
   wire [36:0] dec;
   integer n_mismatch = 0, check_count = 0;

   always #2.5 pclk = ~pclk;

   bscl_latch u_bscl_latch (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .reset_n(reset_n), .clock_generator_reset_n(cg_n),
      .addr_pin_in(a_pin), .addr_board_drive(a_bd), .addr_out(a_out), .addr_oe_n(a_oe_n),
      .data_pin_in(d_pin), .data_board_drive(d_bd), .data_out(d_out), .data_oe_n(d_oe_n),
      .core_addr(c_a), .core_addr_en(c_ae), .core_data(c_d), .core_data_en(c_de),
      .clock_generator_init(cg_init), .core_clock_mult(dec[36:33]),
      .pci_clock_div(dec[32:29]), .external_system_clock_div(dec[28:26]), .pci_host_mode(dec[25]),
      .pci_arbiter_sel(dec[24]), .boot_from_pci(dec[23]), .boot_from_ext_mem(dec[22]),
      .boot_clock_div(dec[21:19]), .boot_sel_reserved(dec[18]),
      .byte_write_enable_mode(dec[17]), .ack_external(dec[16]), .boot_bus_width(dec[15:14]),
      .shared_pin_sel(dec[13:10]), .big_endian(dec[9]), .board_info(dec[8:1]),
      .core_timer_int_en(dec[0]));

   bscl_board u_bscl_board (.strap_addr(s_a), .strap_addr_drv(s_ad), .strap_data(s_d),
      .strap_data_drv(s_dd), .addr_out(a_out), .addr_oe_n(a_oe_n), .data_out(d_out),
      .data_oe_n(d_oe_n), .addr_pin_in(a_pin), .addr_board_drive(a_bd),
      .data_pin_in(d_pin), .data_board_drive(d_bd));

   // Expected decode of captured words, in the port order of dec
   function [36:0] exp_dec(input [19:0] a, input [15:0] d);
      exp_dec = {a[3:0], 4'h8 + {2'h0, a[11:10]}, 3'h4 - {1'h0, a[14:13]}, a[19], d[2],
         a[8:6] == 3'h3, a[8], 3'h4 - {1'h0, a[7:6]}, ~a[8] & ~(a[7] & a[6]), d[5], d[4],
         d[1:0], a[18], a[9], d[6], d[3], a[12], d[15:8], d[7]};
   endfunction

   task check(input [8*8-1:0] what, input [95:0] exp, input [95:0] got);
      begin
         check_count = check_count + 1;
         if (exp !== got) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) begin
            @(posedge pclk);
         end
         rdv = prdata;
         erv = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task rd_chk(input [11:0] a, input [31:0] exp, input e);
      begin
         apb(1'b0, a, 32'h0);
         check("prdata", exp, rdv);
         check("pslverr", e, erv);
      end
   endtask

   // Pulse the chosen resets with straps a/d, then scramble the pins and check
   task boot(input [19:0] a, ad, input [15:0] d, dd, input g, c);
      begin
         @(posedge pclk);
         s_a <= a;
         s_ad <= ad;
         s_d <= d;
         s_dd <= dd;
         if (g) reset_n <= 1'b0;
         if (c) cg_n <= 1'b0;
         repeat (3) @(posedge pclk);
         check("cg_init", c, cg_init);
         reset_n <= 1'b1;
         cg_n <= 1'b1;
         if (g) ea = (ea & `BSCL_ADDR_CG_MASK) |
            (((ad & a) | ~ad | 20'h38000) & `BSCL_ADDR_GEN_MASK);
         if (g) ed = (dd & d) | ~dd;
         if (c) ea = (ea & `BSCL_ADDR_GEN_MASK) | (((ad & a) | ~ad) & `BSCL_ADDR_CG_MASK);
         repeat (2) @(posedge pclk);
         s_a <= ~a;
         s_d <= ~d;
         repeat (3) @(posedge pclk);
         check("decode", exp_dec(ea, ed), dec);
         rd_chk(`BSCL_OFF_ADDR_CFG, {12'h0, ea}, 1'b0);
         rd_chk(`BSCL_OFF_DATA_CFG, {16'h0, ed}, 1'b0);
         $display("boot test done a=%h d=%h", a, d);
      end
   endtask

   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", check_count, n_mismatch);
         if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask

   initial begin
      repeat (8) @(posedge pclk);
      check("decode", exp_dec(ea, ed), dec);
      presetn <= 1'b1;
      boot(20'h00000, 20'hfffff, 16'h0000, 16'hffff, 1'b1, 1'b1);
      boot(20'h834c5, 20'hfffff, 16'h5a3c, 16'hffff, 1'b1, 1'b1);
      boot(20'h44b8a, 20'hfffff, 16'ha5c3, 16'hffff, 1'b0, 1'b1);
      boot(20'h2b471, 20'hfffff, 16'h0ff0, 16'hffff, 1'b1, 1'b0);
      boot(20'h00000, 20'h00000, 16'h0000, 16'h0000, 1'b1, 1'b1);
      check("pads", {c_a, 20'h0, c_d, 16'h0}, {a_out, a_oe_n, d_out, d_oe_n});
      // Per-bit enables: only enabled pads are driven by the core
      c_ae <= 20'h0f0f0;
      c_de <= 16'h00ff;
      repeat (2) @(posedge pclk);
      check("pads_en", {20'hf0f0f, 16'hff00}, {a_oe_n, d_oe_n});
      // Both release flags stand after a joint release; writing ones clears them
      rd_chk(`BSCL_OFF_STATUS, 32'h0000000c, 1'b0);
      apb(1'b1, `BSCL_OFF_STATUS, 32'h0000000c);
      rd_chk(`BSCL_OFF_STATUS, 32'h00000000, 1'b0);
      $display("status test done");
      // Software write reaches the decode; lock refuses later writes
      apb(1'b1, `BSCL_OFF_ADDR_CFG, 32'h12345);
      rd_chk(`BSCL_OFF_ADDR_CFG, 32'h12345, 1'b0);
      check("decode", exp_dec(20'h12345, ed), dec);
      apb(1'b1, `BSCL_OFF_DATA_CFG, 32'h0000a55a);
      rd_chk(`BSCL_OFF_DATA_CFG, 32'h0000a55a, 1'b0);
      check("decode", exp_dec(20'h12345, 16'ha55a), dec);
      apb(1'b1, `BSCL_OFF_CTRL, 32'h1);
      rd_chk(`BSCL_OFF_CTRL, 32'h1, 1'b0);
      apb(1'b1, `BSCL_OFF_ADDR_CFG, 32'h0);
      apb(1'b1, `BSCL_OFF_DATA_CFG, 32'h0);
      rd_chk(`BSCL_OFF_ADDR_CFG, 32'h12345, 1'b0);
      rd_chk(`BSCL_OFF_DATA_CFG, 32'h0000a55a, 1'b0);
      rd_chk(12'h010, 32'h0, 1'b1);
      $display("apb test done");
      report_and_stop;
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (5000) @(posedge pclk);
      n_mismatch = n_mismatch + 1;
      report_and_stop;
   end
endmodule // boot_strap_config_latch_test
